// ---- hw/fan_tach_regs.svh ----
/*
  Register offsets, field positions, reset values and timing counts of the
  fan period monitor and chassis intrusion latch.
  Assumes a 50 MHz core clock and byte-wide register access at the offsets below.
*/
`ifndef FAN_TACH_REGS_SVH
`define FAN_TACH_REGS_SVH

`define REG_CONFIG1 8'h00
`define REG_CONFIG2 8'h01
`define REG_DIV_LOW 8'h02
`define REG_DIV_HIGH 8'h03
`define REG_CONFIG3 8'h05
`define REG_STATUS3 8'h22
`define REG_STATUS4 8'h23
`define REG_FAN_VALUE_BASE 8'h38
`define REG_FAN_LIMIT_BASE 8'h60

`define CFG1_MONITOR_BIT 0
`define CFG1_INT_ENABLE_BIT 1
`define CFG3_RELEASE_BIT 1
`define STATUS4_INTRUSION_BIT 6

`define CONFIG_RESET 8'h00
`define DIV_RESET 8'h55
`define LIMIT_RESET 8'hFF
`define COUNT_FULL 8'hFF
`define COUNT_ZERO 8'h00

`define CLK_FREQ_HZ 50000000
`define OSC_FREQ_HZ 22500
`define OSC_DIV (`CLK_FREQ_HZ / `OSC_FREQ_HZ)
`define SPINUP_TIME_MS 1800
`define SPINUP_CYCLES (`SPINUP_TIME_MS * (`CLK_FREQ_HZ / 1000))
`define WORST_CASE_CLOCKS 509
`define WORST_OSC_PERIOD_US 50

`endif

// ---- hw/fan_tach_pkg.sv ----
/*
  Types shared by the fan period monitor modules.
  Assumes the constants of fan_tach_regs.svh.
*/
package fan_tach_pkg;
  typedef logic [7:0] byte_t;
  typedef enum logic [1:0] {MEAS_IDLE, MEAS_INIT, MEAS_RUN} meas_state_t;
  typedef enum logic [1:0] {SEQ_OFF, SEQ_SPINUP, SEQ_START, SEQ_WAIT} seq_state_t;
endpackage

// ---- hw/fan_meas_if.sv ----
/*
  Link between the channel sequencer and the period counter engine.
  Assumes both ends run on core_clk_i.
*/
`timescale 1ns/1ps
`default_nettype none
interface fan_meas_if;
  logic start;
  logic tach;
  logic is_gpio;
  logic osc_tick;
  logic [1:0] div_code;
  logic done;
  fan_tach_pkg::byte_t result;
  modport ctrl (output start, output tach, output is_gpio, output osc_tick,
    output div_code, input done, input result);
  modport engine (input start, input tach, input is_gpio, input osc_tick,
    input div_code, output done, output result);
endinterface
`default_nettype wire

// ---- hw/fan_tach_counter.sv ----
/*
  Period counter for one fan channel at a time: prescaled oscillator
  ticks counted between tach edges, saturating at full scale.
  Assumes start is a one-cycle pulse and the tach level is synchronous.
*/
`timescale 1ns/1ps
`default_nettype none
`include "fan_tach_regs.svh"
module fan_tach_counter (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  fan_meas_if.engine meas
);
  fan_tach_pkg::meas_state_t state;
  fan_tach_pkg::byte_t count;
  logic [1:0] edges;
  logic tach_q;
  logic [2:0] pre_cnt;
  logic [2:0] pre_mask;
  logic count_tick;
  logic rising;
  logic at_full;

  // Prescaler 1, 2, 4 or 8 ahead of the counter
  assign pre_mask = (meas.div_code == 2'd0) ? 3'd0 :
                    (meas.div_code == 2'd1) ? 3'd1 :
                    (meas.div_code == 2'd2) ? 3'd3 : 3'd7;
  assign count_tick = meas.osc_tick && ((pre_cnt & pre_mask) == pre_mask);
  // GPIO channels see no edges and run to timeout
  assign rising = meas.tach && !tach_q && !meas.is_gpio;
  assign at_full = (count == (`COUNT_FULL - 8'h01));

  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      state <= fan_tach_pkg::MEAS_IDLE;
      count <= `COUNT_ZERO;
      edges <= 2'd0;
      tach_q <= 1'b0;
      pre_cnt <= 3'd0;
      meas.done <= 1'b0;
      meas.result <= `COUNT_ZERO;
    end else begin
      tach_q <= meas.tach;
      meas.done <= 1'b0;
      if (meas.osc_tick) begin
        pre_cnt <= pre_cnt + 3'd1;
      end
      unique case (state)
        fan_tach_pkg::MEAS_IDLE: begin
          if (meas.start) begin
            // Counting begins as soon as the channel is selected
            count <= `COUNT_ZERO;
            edges <= 2'd0;
            pre_cnt <= 3'd0;
            tach_q <= meas.tach;
            state <= fan_tach_pkg::MEAS_INIT;
          end
        end
        fan_tach_pkg::MEAS_INIT: begin
          if (rising && edges == 2'd1) begin
            // Second rising edge clears the counter
            count <= `COUNT_ZERO;
            edges <= 2'd0;
            state <= fan_tach_pkg::MEAS_RUN;
          end else begin
            if (rising) begin
              edges <= edges + 2'd1;
            end
            if (count_tick) begin
              count <= count + 8'h01;
              if (at_full) begin
                // Timeout before second edge, saturated result
                meas.result <= `COUNT_FULL;
                meas.done <= 1'b1;
                state <= fan_tach_pkg::MEAS_IDLE;
              end
            end
          end
        end
        fan_tach_pkg::MEAS_RUN: begin
          if (rising && edges == 2'd1) begin
            // Fourth rising edge ends the measurement
            meas.result <= count;
            meas.done <= 1'b1;
            state <= fan_tach_pkg::MEAS_IDLE;
          end else begin
            if (rising) begin
              edges <= edges + 2'd1;
            end
            if (count_tick) begin
              count <= count + 8'h01;
              if (at_full) begin
                // Reaching 255 marks a failed fan
                meas.result <= `COUNT_FULL;
                meas.done <= 1'b1;
                state <= fan_tach_pkg::MEAS_IDLE;
              end
            end
          end
        end
        default: begin
          state <= fan_tach_pkg::MEAS_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ---- hw/fan_tach_period_and_intrusion.sv ----
/*
  Fan period monitor for eight channels with spin-up delay, underspeed
  status, and a battery-backed chassis intrusion latch, plus its registers.
  Assumes synchronous register strobes and inputs synchronous to core_clk_i.
*/
`timescale 1ns/1ps
`default_nettype none
`include "fan_tach_regs.svh"
module fan_tach_period_and_intrusion #(
  parameter int unsigned OSC_DIV = `OSC_DIV,
  parameter int unsigned SPINUP_CYCLES = `SPINUP_CYCLES
) (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_rvalid_o,
  input wire logic [7:0] fan_tach_i,
  input wire logic intrusion_input_i,
  input wire logic backup_battery_supply_i,
  input wire logic main_power_good_i,
  output logic monitor_start_o,
  output logic alert_n_o
);
  localparam int unsigned FAN_COUNT = 8;
  localparam int unsigned OSC_W = $clog2(OSC_DIV + 1);
  localparam int unsigned SPIN_W = $clog2(SPINUP_CYCLES + 1);
  localparam logic [OSC_W-1:0] OSC_LAST = OSC_W'(OSC_DIV - 1);
  localparam logic [SPIN_W-1:0] SPIN_LAST = SPIN_W'(SPINUP_CYCLES - 1);

  // Address window check for the eight-register blocks
  function automatic logic in_block(input logic [7:0] addr, input logic [7:0] base);
    in_block = (addr[7:3] == base[7:3]);
  endfunction

  fan_meas_if meas ();

  fan_tach_pkg::byte_t config1;
  fan_tach_pkg::byte_t config2;
  fan_tach_pkg::byte_t div_low;
  fan_tach_pkg::byte_t div_high;
  fan_tach_pkg::byte_t config3;
  fan_tach_pkg::byte_t status3;
  logic under_flag [FAN_COUNT];
  fan_tach_pkg::byte_t fan_value [FAN_COUNT];
  fan_tach_pkg::byte_t fan_limit [FAN_COUNT];
  logic intrusion;
  logic monitor_q;
  fan_tach_pkg::seq_state_t seq;
  logic [2:0] chan;
  logic [SPIN_W-1:0] spin_cnt;
  logic [OSC_W-1:0] osc_cnt;
  logic osc_tick;

  // Write decode
  wire wr_config1 = reg_wr_i && (reg_addr_i == `REG_CONFIG1);
  wire wr_config2 = reg_wr_i && (reg_addr_i == `REG_CONFIG2);
  wire wr_div_low = reg_wr_i && (reg_addr_i == `REG_DIV_LOW);
  wire wr_div_high = reg_wr_i && (reg_addr_i == `REG_DIV_HIGH);
  wire wr_config3 = reg_wr_i && (reg_addr_i == `REG_CONFIG3);
  wire wr_limit = reg_wr_i && in_block(reg_addr_i, `REG_FAN_LIMIT_BASE);
  wire [2:0] reg_slot = reg_addr_i[2:0];

  // Monitoring starts on a rising monitor-enable bit
  wire monitor_on = config1[`CFG1_MONITOR_BIT];
  wire monitor_rise = monitor_on && !monitor_q;
  wire spin_done = (spin_cnt == SPIN_LAST);

  // Per-channel selections
  wire [15:0] div_all = {div_high, div_low};
  wire [1:0] sel_div = div_all[{chan, 1'b0} +: 2];
  wire sel_tach = fan_tach_i[chan];
  wire sel_gpio = config2[chan];

  // Intrusion latch terms
  wire intrusion_set = intrusion_input_i && (backup_battery_supply_i || main_power_good_i);
  wire intrusion_release = config3[`CFG3_RELEASE_BIT] && backup_battery_supply_i;
  wire next_intrusion = intrusion_set || (intrusion && !intrusion_release);

  // Interrupt pin only while enabled and main power is up
  assign status3 = {under_flag[7], under_flag[6], under_flag[5], under_flag[4],
                    under_flag[3], under_flag[2], under_flag[1], under_flag[0]};
  wire alert_cause = intrusion || (|status3);
  wire next_alert_n = !(config1[`CFG1_INT_ENABLE_BIT] && main_power_good_i && alert_cause);

  // Read selection
  wire [7:0] status4 = {1'b0, intrusion, 6'b00_0000};
  wire [7:0] rd_value = (reg_addr_i == `REG_CONFIG1) ? config1 :
                        (reg_addr_i == `REG_CONFIG2) ? config2 :
                        (reg_addr_i == `REG_DIV_LOW) ? div_low :
                        (reg_addr_i == `REG_DIV_HIGH) ? div_high :
                        (reg_addr_i == `REG_CONFIG3) ? config3 :
                        (reg_addr_i == `REG_STATUS3) ? status3 :
                        (reg_addr_i == `REG_STATUS4) ? status4 :
                        in_block(reg_addr_i, `REG_FAN_VALUE_BASE) ? fan_value[reg_slot] :
                        in_block(reg_addr_i, `REG_FAN_LIMIT_BASE) ? fan_limit[reg_slot] :
                        `COUNT_ZERO;

  // Engine connections
  assign meas.start = (seq == fan_tach_pkg::SEQ_START);
  assign meas.tach = sel_tach;
  assign meas.is_gpio = sel_gpio;
  assign meas.osc_tick = osc_tick;
  assign meas.div_code = sel_div;

  fan_tach_counter counter_u (
    .core_clk_i(core_clk_i),
    .reset_n_i(reset_n_i),
    .meas(meas)
  );

  // Configuration registers
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      config1 <= `CONFIG_RESET;
      config2 <= `CONFIG_RESET;
      div_low <= `DIV_RESET;
      div_high <= `DIV_RESET;
      config3 <= `CONFIG_RESET;
      monitor_q <= 1'b0;
    end else begin
      monitor_q <= monitor_on;
      if (wr_config1) begin
        config1 <= reg_wdata_i;
      end
      if (wr_config2) begin
        config2 <= reg_wdata_i;
      end
      if (wr_div_low) begin
        div_low <= reg_wdata_i;
      end
      if (wr_div_high) begin
        div_high <= reg_wdata_i;
      end
      if (wr_config3) begin
        config3 <= reg_wdata_i;
      end
    end
  end

  // Limit registers
  generate
    for (genvar i = 0; i < FAN_COUNT; i++) begin : g_limit
      always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
          fan_limit[i] <= `LIMIT_RESET;
        end else if (wr_limit && reg_slot == 3'(i)) begin
          fan_limit[i] <= reg_wdata_i;
        end
      end
    end
  endgenerate

  // Free-running 22.5 kHz oscillator tick
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      osc_cnt <= '0;
      osc_tick <= 1'b0;
    end else begin
      osc_tick <= (osc_cnt == OSC_LAST);
      if (osc_cnt == OSC_LAST) begin
        osc_cnt <= '0;
      end else begin
        osc_cnt <= osc_cnt + OSC_W'(1);
      end
    end
  end

  // Channel sequencer with spin-up delay
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      seq <= fan_tach_pkg::SEQ_OFF;
      chan <= 3'd0;
      spin_cnt <= '0;
      monitor_start_o <= 1'b0;
    end else begin
      // Shared start pulse for the analog sequence
      monitor_start_o <= monitor_rise;
      if (!monitor_on) begin
        seq <= fan_tach_pkg::SEQ_OFF;
      end else if (monitor_rise) begin
        seq <= fan_tach_pkg::SEQ_SPINUP;
        spin_cnt <= '0;
        chan <= 3'd0;
      end else begin
        unique case (seq)
          fan_tach_pkg::SEQ_OFF: begin
            seq <= fan_tach_pkg::SEQ_OFF;
          end
          fan_tach_pkg::SEQ_SPINUP: begin
            if (spin_done) begin
              seq <= fan_tach_pkg::SEQ_START;
            end else begin
              spin_cnt <= spin_cnt + SPIN_W'(1);
            end
          end
          fan_tach_pkg::SEQ_START: begin
            seq <= fan_tach_pkg::SEQ_WAIT;
          end
          fan_tach_pkg::SEQ_WAIT: begin
            if (meas.done) begin
              // Next channel, wrapping after 7
              chan <= chan + 3'd1;
              seq <= fan_tach_pkg::SEQ_START;
            end
          end
        endcase
      end
    end
  end

  // Fan values and underspeed status
  generate
    for (genvar i = 0; i < FAN_COUNT; i++) begin : g_value
      always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
          fan_value[i] <= `COUNT_ZERO;
          under_flag[i] <= 1'b0;
        end else if (monitor_rise) begin
          fan_value[i] <= `COUNT_ZERO;
        end else if (meas.done && seq == fan_tach_pkg::SEQ_WAIT && chan == 3'(i)) begin
          fan_value[i] <= meas.result;
          under_flag[i] <= (meas.result > fan_limit[i]);
        end
      end
    end
  endgenerate

  // Intrusion latch, set wins over release
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      intrusion <= 1'b0;
    end else begin
      intrusion <= next_intrusion;
    end
  end

  // Interrupt pin
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      alert_n_o <= 1'b1;
    end else begin
      alert_n_o <= next_alert_n;
    end
  end

  // Registered read data
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      reg_rdata_o <= `COUNT_ZERO;
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rvalid_o <= reg_rd_i;
      if (reg_rd_i) begin
        reg_rdata_o <= rd_value;
      end
    end
  end
endmodule
`default_nettype wire

// ---- testbench/fan_tach_model.sv ----
/*
  Far-side model: eight fan tach outputs and the intrusion switch.
  Assumes one shared tach half period of HALF core clock cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module fan_tach_model #(
  parameter int unsigned HALF = 100
) (
  input wire logic core_clk_i,
  input wire logic [7:0] run_mask_i,
  input wire logic intrusion_req_i,
  output logic [7:0] fan_tach_o,
  output logic intrusion_input_o
);
  int unsigned ticks = 0;
  logic phase = 1'b0;
  always @(posedge core_clk_i) begin
    if (ticks == HALF - 1) begin
      ticks <= 0;
      phase <= ~phase;
    end else begin
      ticks <= ticks + 1;
    end
  end
  // Stopped fans sit at the pull-up level
  assign fan_tach_o = (run_mask_i & {8{phase}}) | ~run_mask_i;
  assign intrusion_input_o = intrusion_req_i;
endmodule
`default_nettype wire

// ---- testbench/fan_tach_assertions.sv ----
/*
  Port checker for the fan period monitor and intrusion latch.
  Assumes a bind to the top module and its register strobe timing.
*/
`timescale 1ns/1ps
`default_nettype none
module fan_tach_checker #(
  parameter int unsigned OSC_DIV = 4,
  parameter int unsigned SPINUP_CYCLES = 200
) (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic reg_rvalid_o,
  input wire logic [7:0] fan_tach_i,
  input wire logic intrusion_input_i,
  input wire logic backup_battery_supply_i,
  input wire logic main_power_good_i,
  input wire logic monitor_start_o,
  input wire logic alert_n_o
);
  logic div_written;
  wire logic wr_mon = reg_wr_i && reg_addr_i == 8'h00 && reg_wdata_i[0];
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      div_written <= 1'b0;
    end else if (reg_wr_i && reg_addr_i inside {8'h02, 8'h03}) begin
      div_written <= 1'b1;
    end
  end
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);
  AST_RVALID_PULSE: assert property (reg_rd_i |=> reg_rvalid_o)
    else $error("read not answered");
  AST_RVALID_CAUSE: assert property (!reg_rd_i |=> !reg_rvalid_o)
    else $error("read valid without read");
  AST_RDATA_HOLD: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
    else $error("read data moved without read");
  AST_UNMAPPED: assert property (reg_rd_i && reg_addr_i == 8'h10 |=> reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  AST_DIV_DEFAULT: assert property (
    reg_rd_i && reg_addr_i inside {8'h02, 8'h03} && !div_written |=> reg_rdata_o == 8'h55)
    else $error("divisor default wrong");
  AST_START_ONE: assert property (monitor_start_o |=> !monitor_start_o)
    else $error("start pulse too long");
  AST_START_CAUSE: assert property (
    monitor_start_o |-> $past(wr_mon, 1) || $past(wr_mon, 2))
    else $error("start pulse without monitor write");
  AST_ALERT_POWER: assert property (!main_power_good_i |=> alert_n_o)
    else $error("alert while main power off");
  AST_INTRUSION_LATCH: assert property (
    intrusion_input_i && backup_battery_supply_i ##1 reg_rd_i && reg_addr_i == 8'h23
    |=> reg_rdata_o[6])
    else $error("intrusion not latched");
endmodule
bind fan_tach_period_and_intrusion fan_tach_checker #(
  .OSC_DIV(OSC_DIV),
  .SPINUP_CYCLES(SPINUP_CYCLES)
) chk_u (
  .core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o), .fan_tach_i(fan_tach_i),
  .intrusion_input_i(intrusion_input_i), .backup_battery_supply_i(backup_battery_supply_i),
  .main_power_good_i(main_power_good_i), .monitor_start_o(monitor_start_o),
  .alert_n_o(alert_n_o)
);
`default_nettype wire

// ---- testbench/testbench.sv ----
/*
  Self-checking bench for the fan period monitor and intrusion latch.
  Assumes OSC_DIV 4, SPINUP_CYCLES 200 and a tach period of 200 cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic core_clk_i = 1'b0, reset_n_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, run_mask = 8'hFF;
  logic battery = 1'b1, main_power = 1'b1, intr_req = 1'b0;
  logic [7:0] reg_rdata_o, fan_tach;
  logic reg_rvalid_o, monitor_start_o, alert_n_o, intrusion;
  int failures = 0, total_checks = 0, cycles = 0;
  fan_tach_period_and_intrusion #(.OSC_DIV(4), .SPINUP_CYCLES(200)) dut_u (
    .core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o), .fan_tach_i(fan_tach),
    .intrusion_input_i(intrusion), .backup_battery_supply_i(battery),
    .main_power_good_i(main_power), .monitor_start_o(monitor_start_o),
    .alert_n_o(alert_n_o));
  fan_tach_model #(.HALF(100)) far_u (.core_clk_i(core_clk_i), .run_mask_i(run_mask),
    .intrusion_req_i(intr_req), .fan_tach_o(fan_tach), .intrusion_input_o(intrusion));
  initial begin
    forever #10 core_clk_i = ~core_clk_i;
  end
  task automatic report_and_stop();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 40000) begin
      failures++;
      report_and_stop();
    end
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic chk_in(input logic [7:0] v, input logic [7:0] lo, input logic [7:0] hi);
    chk({7'h00, (v >= lo) && (v <= hi)}, 8'h01);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk_i);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    @(negedge core_clk_i);
    reg_wr_i = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge core_clk_i);
    reg_addr_i = a;
    reg_rd_i = 1'b1;
    @(negedge core_clk_i);
    reg_rd_i = 1'b0;
    d = reg_rdata_o;
    chk({7'h00, reg_rvalid_o}, 8'h01);
  endtask
  task automatic check_reset_values();
    logic [7:0] v;
    rd(8'h00, v); chk(v, 8'h00);
    rd(8'h01, v); chk(v, 8'h00);
    rd(8'h02, v); chk(v, 8'h55);
    rd(8'h03, v); chk(v, 8'h55);
    rd(8'h10, v); chk(v, 8'h00);
    wr(8'h22, 8'hFF);
    rd(8'h22, v); chk(v, 8'h00);
  endtask
  task automatic check_intrusion();
    logic [7:0] v;
    main_power = 1'b0;
    wr(8'h00, 8'h02);
    intr_req = 1'b1;
    rd(8'h23, v); chk(v, 8'h40);
    intr_req = 1'b0;
    repeat (5) @(negedge core_clk_i);
    rd(8'h23, v); chk(v, 8'h40);
    chk({7'h00, alert_n_o}, 8'h01);
    main_power = 1'b1;
    repeat (3) @(negedge core_clk_i);
    chk({7'h00, alert_n_o}, 8'h00);
    wr(8'h05, 8'h02);
    rd(8'h23, v); chk(v, 8'h00);
    wr(8'h05, 8'h00);
    repeat (3) @(negedge core_clk_i);
    chk({7'h00, alert_n_o}, 8'h01);
  endtask
  task automatic check_spinup();
    logic [7:0] v;
    wr(8'h01, 8'h40);
    wr(8'h02, 8'h35);
    wr(8'h61, 8'h10);
    wr(8'h67, 8'hFE);
    run_mask = 8'h7F;
    wr(8'h00, 8'h03);
    rd(8'h38, v); chk(v, 8'h00);
    rd(8'h02, v); chk(v, 8'h35);
  endtask
  task automatic check_measurement();
    logic [7:0] v;
    int n;
    v = 8'h00;
    for (n = 0; n < 150 && v === 8'h00; n++) begin
      repeat (100) @(negedge core_clk_i);
      rd(8'h3F, v);
    end
    chk(v, 8'hFF);
    rd(8'h3E, v); chk(v, 8'hFF);
    rd(8'h38, v); chk_in(v, 8'd49, 8'd51);
    rd(8'h39, v); chk_in(v, 8'd49, 8'd51);
    rd(8'h3A, v); chk_in(v, 8'd11, 8'd14);
    rd(8'h3B, v); chk_in(v, 8'd99, 8'd101);
    rd(8'h3C, v); chk_in(v, 8'd49, 8'd51);
    rd(8'h22, v); chk(v, 8'h82);
    chk({7'h00, alert_n_o}, 8'h00);
  endtask
  initial begin
    repeat (3) @(negedge core_clk_i);
    reset_n_i = 1'b1;
    check_reset_values();
    check_intrusion();
    check_spinup();
    check_measurement();
    report_and_stop();
  end
endmodule
`default_nettype wire
